// ===== verilog/ddc_pkg.sv
// Purpose: Shared constants for the dual converter serial load and clear block
// Assumes: 24-bit write frames, two channels
// Notes: Only the channel select bit and code field of the frame word are decoded here; the rest is decoded elsewhere
package ddc_pkg;
    localparam int FRAME_BITS = 24;
    localparam int CNT_W = 5;
    localparam int CODE_W = 16;
    localparam logic [4:0] CNT_ZERO = 5'h00;
    localparam logic [4:0] CNT_LAST = 5'h17;
    localparam logic [15:0] ZERO_CODE = 16'h0000;
    localparam logic [23:0] WORD_ZERO = 24'h000000;
    // Frame word layout used to pick the target channel and code
    localparam int SEL_BIT = 16;
    localparam int CODE_LSB = 0;
endpackage

// ===== verilog/ddc_serial_dac.sv
// Purpose: Serial write port, input and converter registers, load and clear
// Assumes: i_clk 100 MHz system clock, i_sclk link clock up to 50 MHz
// Notes: Frame words cross to i_clk by toggle handshake
`timescale 1ns/100ps
module ddc_serial_dac #(
    parameter int CODE_W = ddc_pkg::CODE_W
) (
    // System clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Serial link
    input wire logic i_sclk,
    input wire logic i_frame_sel_n,
    input wire logic i_din,
    // Hardware strobes
    input wire logic i_load_strobe_n,
    input wire logic i_async_zero_clear_n,
    input wire logic i_int_ref_sel,
    // Converter codes
    output logic [CODE_W-1:0] o_channel_a_output,
    output logic [CODE_W-1:0] o_channel_b_output,
    // Frame word to command decoder
    output logic [23:0] o_frame_word,
    output logic o_frame_valid,
    // Status
    output logic o_clear_mode,
    output logic o_shared_reference_pin_oe
);
    // ----------------------------------------
    // Link domain: shifter on falling sclk
    // ----------------------------------------
    logic [23:0] shift;
    logic [23:0] next_shift;
    logic [4:0] bit_cnt;
    logic [4:0] next_bit_cnt;
    logic [23:0] word;
    logic [23:0] next_word;
    logic word_tgl;
    logic next_word_tgl;
    logic clr_seen;

    // ----------------------------------------
    // Link domain: frame reset
    // ----------------------------------------
    // no sclk edge needed
    // Clear and power-up act on the shifter at once, even with sclk stopped.
    // Release is not synchronised to sclk; the host keeps sclk idle outside
    // frames, so no falling edge can race the release.
    assign clr_seen = i_async_zero_clear_n & i_rst_n;

    always_comb begin
        next_shift = shift;
        next_bit_cnt = bit_cnt;
        next_word = word;
        next_word_tgl = word_tgl;
        if (!i_frame_sel_n) begin
            next_shift = {shift[22:0], i_din};
            next_bit_cnt = bit_cnt + 5'h01;
            // The counter wraps on the 24th edge, so frames may follow back to back
            // act on 24th edge
            if (bit_cnt == ddc_pkg::CNT_LAST) begin
                next_word = {shift[22:0], i_din};
                next_word_tgl = ~word_tgl;
                next_bit_cnt = ddc_pkg::CNT_ZERO;
            end
        end
    end

    always_ff @(negedge i_sclk or posedge i_frame_sel_n or negedge clr_seen) begin
        if (!clr_seen) begin
            shift <= ddc_pkg::WORD_ZERO;
            bit_cnt <= ddc_pkg::CNT_ZERO;
        end else if (i_frame_sel_n) begin
            shift <= ddc_pkg::WORD_ZERO;
            bit_cnt <= ddc_pkg::CNT_ZERO;
        end else begin
            shift <= next_shift;
            bit_cnt <= next_bit_cnt;
        end
    end

    // Word and toggle clear only at power-up, so an abort or a clear cannot
    // fake a toggle; the system side starts from the same toggle level.
    always_ff @(negedge i_sclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            word <= ddc_pkg::WORD_ZERO;
            word_tgl <= 1'b0;
        end else begin
            word <= next_word;
            word_tgl <= next_word_tgl;
        end
    end

    // ----------------------------------------
    // System domain: synchronisers
    // ----------------------------------------
    logic [2:0] tgl_s;
    logic [2:0] ld_s;
    logic [2:0] clr_s;
    logic [2:0] ref_s;
    logic tgl_seen;
    logic ld_state;
    logic clr_state;
    // The toggle crosses as one bit; the word stays still until the next
    // frame ends, so it is read here without a synchroniser of its own.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            tgl_s <= 3'h0;
            ref_s <= 3'h0;
            ld_s <= 3'h7;
            clr_s <= 3'h7;
        end else begin
            tgl_s <= {tgl_s[1:0], word_tgl};
            ld_s <= {ld_s[1:0], i_load_strobe_n};
            clr_s <= {clr_s[1:0], i_async_zero_clear_n};
            ref_s <= {ref_s[1:0], i_int_ref_sel};
        end
    end

    // ----------------------------------------
    // System domain: registers
    // ----------------------------------------
    logic [CODE_W-1:0] in_reg [2];
    logic [CODE_W-1:0] dac_reg [2];
    logic [1:0] pend;
    logic clear_mode;
    logic [23:0] fword;
    logic fvalid;
    logic ref_out;
    logic [CODE_W-1:0] next_in_reg [2];
    logic [CODE_W-1:0] next_dac_reg [2];
    logic [1:0] next_pend;
    logic next_clear_mode;
    logic next_tgl_seen;
    logic next_ld_state;
    logic next_clr_state;
    logic [23:0] next_fword;
    logic next_fvalid;
    logic next_ref_out;
    logic new_word;
    logic clr_fall;
    logic ld_fall;
    logic ch;
    logic frame_ok;

    always_comb begin
        next_tgl_seen = tgl_seen;
        next_ld_state = ld_state;
        next_clr_state = clr_state;
        // A change counts only once the second and third flops agree
        if (tgl_s[2] == tgl_s[1]) begin
            next_tgl_seen = tgl_s[2];
        end
        if (ld_s[2] == ld_s[1]) begin
            next_ld_state = ld_s[2];
        end
        if (clr_s[2] == clr_s[1]) begin
            next_clr_state = clr_s[2];
        end
        new_word = next_tgl_seen != tgl_seen;
        clr_fall = clr_state & ~next_clr_state;
        ld_fall = ld_state & ~next_ld_state;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            tgl_seen <= 1'b0;
            ld_state <= 1'b1;
            clr_state <= 1'b1;
        end else begin
            tgl_seen <= next_tgl_seen;
            ld_state <= next_ld_state;
            clr_state <= next_clr_state;
        end
    end

    // ----------------------------------------
    // System domain: register updates
    // ----------------------------------------
    // Clear is applied last so it wins over a frame or a load in the same cycle
    always_comb begin
        // Channel select bit is a local choice; the frame word goes out whole
        ch = word[ddc_pkg::SEL_BIT];
        // Words finished while clear was low are the aborted frame
        frame_ok = new_word & next_clr_state;
        next_in_reg = in_reg;
        next_dac_reg = dac_reg;
        next_pend = pend;
        next_clear_mode = clear_mode;
        next_fword = fword;
        next_fvalid = 1'b0;
        // select is a pin, filtered like the strobes
        next_ref_out = ref_out | (ref_s[2] & ref_s[1]);
        if (frame_ok) begin
            next_fword = word;
            next_fvalid = 1'b1;
            next_in_reg[ch] = word[ddc_pkg::CODE_LSB +: CODE_W];
            next_pend[ch] = 1'b1;
            next_clear_mode = 1'b0;
        end
        if (next_clr_state && (ld_fall || !next_ld_state)) begin
            for (int i = 0; i < 2; i++) begin
                if (next_pend[i]) begin
                    next_dac_reg[i] = next_in_reg[i];
                end
            end
            next_pend = 2'h0;
        end
        // zero the input and converter registers of both channels
        // Pending flags drop too, so a later strobe cannot revive a cleared code
        if (clr_fall) begin
            for (int i = 0; i < 2; i++) begin
                next_in_reg[i] = ddc_pkg::ZERO_CODE[CODE_W-1:0];
                next_dac_reg[i] = ddc_pkg::ZERO_CODE[CODE_W-1:0];
            end
            next_pend = 2'h0;
            next_clear_mode = 1'b1;
            next_fvalid = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            for (int i = 0; i < 2; i++) begin
                in_reg[i] <= ddc_pkg::ZERO_CODE[CODE_W-1:0];
                dac_reg[i] <= ddc_pkg::ZERO_CODE[CODE_W-1:0];
            end
            pend <= 2'h0;
            clear_mode <= 1'b0;
            fword <= ddc_pkg::WORD_ZERO;
            fvalid <= 1'b0;
            ref_out <= 1'b0;
        end else begin
            in_reg <= next_in_reg;
            dac_reg <= next_dac_reg;
            pend <= next_pend;
            clear_mode <= next_clear_mode;
            fword <= next_fword;
            fvalid <= next_fvalid;
            ref_out <= next_ref_out;
        end
    end

    // ----------------------------------------
    // System domain: outputs
    // ----------------------------------------
    // Codes register the next value so both channels move on the same edge
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_channel_a_output <= ddc_pkg::ZERO_CODE[CODE_W-1:0];
            o_channel_b_output <= ddc_pkg::ZERO_CODE[CODE_W-1:0];
        end else begin
            o_channel_a_output <= next_dac_reg[0];
            o_channel_b_output <= next_dac_reg[1];
        end
    end
    // Status outputs come straight from their registers
    assign o_frame_word = fword;
    assign o_frame_valid = fvalid;
    assign o_clear_mode = clear_mode;
    assign o_shared_reference_pin_oe = ref_out;
endmodule

// ===== tb/ddc_host_model.sv
// Purpose: Serial master driving write frames into the converter block
// Assumes: 30 ns link clock, idle high, running only inside frames
// Notes: Released data line is inverted so a stale bit cannot pass
`timescale 1ns/100ps
module ddc_host_model (
    output logic o_sclk,
    output logic o_frame_sel_n,
    output logic o_din
);
    initial begin
        o_sclk = 1'b1;
        o_frame_sel_n = 1'b1;
        o_din = 1'b0;
    end
    task automatic send(input logic [23:0] w, input int n);
        o_frame_sel_n = 1'b0;
        for (int i = 23; i > 23 - n; i--) begin
            o_din = w[i];
            #15 o_sclk = 1'b0;
            #15 o_sclk = 1'b1;
        end
        #15 o_frame_sel_n = 1'b1;
        o_din = ~o_din;
        #30;
    endtask
endmodule

// ===== tb/ddc_serial_dac_assertions.sv
// Purpose: Port checks for the serial converter block
// Assumes: All checks on the system clock
// Notes: Bound to every instance of the block
`timescale 1ns/100ps
module ddc_serial_dac_assertions #(
    parameter int CODE_W = 16
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_load_strobe_n,
    input wire logic i_async_zero_clear_n,
    input wire logic i_int_ref_sel,
    input wire logic [CODE_W-1:0] o_channel_a_output,
    input wire logic [CODE_W-1:0] o_channel_b_output,
    input wire logic [23:0] o_frame_word,
    input wire logic o_frame_valid,
    input wire logic o_clear_mode,
    input wire logic o_shared_reference_pin_oe
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    a_valid_one_cycle: assert property (o_frame_valid |=> !o_frame_valid)
        else $error("frame valid too long");
    a_clear_zeroes_all: assert property ($fell(i_async_zero_clear_n) |-> ##[1:8]
        (o_channel_a_output == 0 && o_channel_b_output == 0 && o_clear_mode))
        else $error("clear did not zero outputs");
    a_clear_exit_frame: assert property ($fell(o_clear_mode) |->
        o_frame_valid || $past(o_frame_valid)) else $error("clear mode left early");
    a_clear_blocks_load: assert property ((!i_async_zero_clear_n)[*8] |=>
        $stable(o_channel_a_output) && $stable(o_channel_b_output))
        else $error("transfer during clear");
    a_idle_no_update: assert property ((i_load_strobe_n && i_async_zero_clear_n)[*8] |=>
        $stable(o_channel_a_output) && $stable(o_channel_b_output))
        else $error("outputs moved without strobe");
    a_held_strobe_load: assert property ((!i_load_strobe_n)[*8] ##0 o_frame_valid |-> ##[0:1]
        (o_frame_word[16] ? o_channel_b_output : o_channel_a_output) == o_frame_word[15:0])
        else $error("held strobe did not transfer");
    a_ref_needs_select: assert property ($rose(o_shared_reference_pin_oe) |->
        $past(i_int_ref_sel) || $past(i_int_ref_sel, 2) || $past(i_int_ref_sel, 3))
        else $error("reference output without select");
    a_ref_sticky: assert property (o_shared_reference_pin_oe |=> o_shared_reference_pin_oe)
        else $error("reference output dropped");
    c_frame: cover property (o_frame_valid);
    c_clear_exit: cover property (o_clear_mode ##1 !o_clear_mode);
    c_ref: cover property ($rose(o_shared_reference_pin_oe));
endmodule
bind ddc_serial_dac ddc_serial_dac_assertions #(.CODE_W(CODE_W)) chk (.i_clk, .i_rst_n,
    .i_load_strobe_n, .i_async_zero_clear_n, .i_int_ref_sel, .o_channel_a_output,
    .o_channel_b_output, .o_frame_word, .o_frame_valid, .o_clear_mode,
    .o_shared_reference_pin_oe);

// ===== tb/dual_dac_serial_load_clear_test.sv
// Purpose: Self-checking bench for the serial converter block
// Assumes: 100 MHz system clock, host model on the link
// Notes: Scenario tasks run back to back from one reset
`timescale 1ns/100ps
module dual_dac_serial_load_clear_test;
    logic i_clk = 1'b0, i_rst_n = 1'b1, ld_n = 1'b1, clr_n = 1'b1, ref_sel = 1'b0;
    logic sclk, fs_n, din, fv, cm, oe;
    logic [15:0] a, b;
    logic [23:0] word;
    int miscompares = 0, checks = 0, nvalid = 0, cycles = 0;
    always #5 i_clk = ~i_clk;
    ddc_host_model host (.o_sclk(sclk), .o_frame_sel_n(fs_n), .o_din(din));
    ddc_serial_dac dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sclk(sclk), .i_frame_sel_n(fs_n),
        .i_din(din), .i_load_strobe_n(ld_n), .i_async_zero_clear_n(clr_n),
        .i_int_ref_sel(ref_sel), .o_channel_a_output(a), .o_channel_b_output(b),
        .o_frame_word(word), .o_frame_valid(fv), .o_clear_mode(cm),
        .o_shared_reference_pin_oe(oe));
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Hang guard well above the expected run length
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (fv === 1'b1)
            nvalid <= nvalid + 1;
        if (cycles == 4000) begin
            miscompares++;
            results;
        end
    end
    task automatic wait_valid(input int n0);
        for (int k = 0; k < 300 && nvalid == n0; k++)
            @(posedge i_clk);
        check(nvalid, n0 + 1);
    endtask
    task automatic pulse_load;
        ld_n <= 1'b0;
        repeat (6) @(posedge i_clk);
        ld_n <= 1'b1;
        repeat (10) @(posedge i_clk);
    endtask
    task automatic t_pulsed;
        int n0 = nvalid;
        host.send(24'hA41234, 24);
        wait_valid(n0);
        check(word, 24'hA41234);
        check(a, 16'h0000);
        pulse_load;
        check(a, 16'h1234);
    endtask
    task automatic t_held;
        int n0 = nvalid;
        ld_n <= 1'b0;
        host.send(24'h01BEEF, 24);
        wait_valid(n0);
        repeat (2) @(posedge i_clk);
        check(b, 16'hBEEF);
        ld_n <= 1'b1;
    endtask
    task automatic t_abort;
        int n0 = nvalid;
        host.send(24'h00FFFF, 23);
        repeat (40) @(posedge i_clk);
        check(nvalid, n0);
        pulse_load;
        check(a, 16'h1234);
    endtask
    task automatic t_clear;
        int n0 = nvalid;
        fork
            host.send(24'h005555, 24);
            begin
                repeat (30) @(posedge i_clk);
                clr_n <= 1'b0;
            end
        join
        repeat (10) @(posedge i_clk);
        check(nvalid, n0);
        check(a, 16'h0000);
        check(b, 16'h0000);
        pulse_load;
        clr_n <= 1'b1;
        pulse_load;
        check(cm, 1'b1);
        host.send(24'h004321, 24);
        wait_valid(n0);
        repeat (2) @(posedge i_clk);
        check(cm, 1'b0);
    endtask
    task automatic t_ref;
        check(oe, 1'b0);
        ref_sel <= 1'b1;
        repeat (6) @(posedge i_clk);
        ref_sel <= 1'b0;
        repeat (3) @(posedge i_clk);
        check(oe, 1'b1);
    endtask
    initial begin
        i_rst_n <= 1'b0;
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        check(a, 16'h0000);
        check(b, 16'h0000);
        t_pulsed;
        t_held;
        t_abort;
        t_clear;
        t_ref;
        results;
    end
endmodule
